//--- tldtpr_regs.sv
// axi4-lite register bank: corner temperatures, temperature sum, led delay, pll and clock control
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tldtpr_cfg.svh"

// Summary of operation
// - seven corner temperature results are read-only registers
// - read-only sum of four conversions, one taken every fourth row readout
// - fine led delay in 10 ps steps over two registers, limit 799, reset 0
// - coarse led delay in 2 ns steps, limit 49, reset 0
// - delay settings apply only while delay-enable bit 2 is set
// - mode-control bit 2 runs the pll; reset value 0x04
module tldtpr_regs #(
    parameter int AW     = 12,
    parameter int CONV_W = 6
) (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire logic [AW-1:0]           awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    input  wire logic [AW-1:0]           araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    input  wire tldtpr_pkg::tldtpr_temps_t temps,
    input  wire logic                    row_done,
    input  wire logic [CONV_W-1:0]       temp_conv,
    output logic                         pll_enable,
    output logic [7:0]                   clock_control,
    output tldtpr_pkg::tldtpr_dly_out_t  led_delay
);
    import tldtpr_pkg::*;

    // ==========================================================
    // register storage
    logic [7:0]  led_fine_delay_a;
    logic [7:0]  led_fine_delay_b;
    logic [7:0]  led_coarse_delay;
    logic        delay_enable;
    logic [7:0]  temp_sum_four_readings;

    // write channel holding
    logic          aw_got;
    logic          w_got;
    logic [AW-1:0] aw_addr_q;
    logic [31:0]   w_data_q;
    logic [3:0]    w_strb_q;
    logic          next_aw_got;
    logic          next_w_got;
    logic          next_bvalid;
    logic          wr_fire;
    logic          wr_hit;
    logic          wr_lane0;
    logic [7:0]    wr_idx;

    // temperature accumulation
    logic [1:0]  row_cnt;
    logic [1:0]  conv_cnt;
    logic [7:0]  temp_acc;
    logic        conv_take;
    logic [7:0]  acc_plus;

    tldtpr_dly_cfg_t dly_cfg;

    // ==========================================================
    // address decode
    function automatic logic addr_in_range(input logic [AW-1:0] a);
        addr_in_range = (a >> 10) == '0;
    endfunction

    function automatic logic [7:0] addr_index(input logic [AW-1:0] a);
        addr_index = a[9:2];
    endfunction

    function automatic logic idx_mapped(input logic [7:0] idx);
        case (idx)
            `TLDTPR_IDX_TEMP_TL,
            `TLDTPR_IDX_TEMP_SUM,
            `TLDTPR_IDX_TEMP_TR,
            `TLDTPR_IDX_TEMP_TR_AUX,
            `TLDTPR_IDX_TEMP_BL,
            `TLDTPR_IDX_TEMP_BL_AUX,
            `TLDTPR_IDX_TEMP_BR,
            `TLDTPR_IDX_TEMP_BR_AUX,
            `TLDTPR_IDX_FINE_A,
            `TLDTPR_IDX_FINE_B,
            `TLDTPR_IDX_COARSE,
            `TLDTPR_IDX_MODE,
            `TLDTPR_IDX_CLK_CTRL,
            `TLDTPR_IDX_DLY_EN: idx_mapped = 1'b1;
            default:            idx_mapped = 1'b0;
        endcase
    endfunction

    // ==========================================================
    // write path: address and data taken in either order
    assign wr_fire  = aw_got && w_got && !bvalid;
    assign wr_idx   = addr_index(aw_addr_q);
    assign wr_hit   = addr_in_range(aw_addr_q) && idx_mapped(wr_idx);
    assign wr_lane0 = wr_fire && wr_hit && w_strb_q[0];

    always_comb begin
        next_aw_got = aw_got;
        next_w_got  = w_got;
        next_bvalid = bvalid;
        if (awvalid && awready) begin
            next_aw_got = 1'b1;
        end
        if (wvalid && wready) begin
            next_w_got = 1'b1;
        end
        if (wr_fire) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
        end else if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            bvalid  <= 1'b0;
            awready <= 1'b0;
            wready  <= 1'b0;
        end else begin
            aw_got  <= next_aw_got;
            w_got   <= next_w_got;
            bvalid  <= next_bvalid;
            awready <= !next_aw_got && !next_bvalid;
            wready  <= !next_w_got && !next_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bresp <= `TLDTPR_RESP_OKAY;
        end else if (wr_fire) begin
            bresp <= wr_hit ? `TLDTPR_RESP_OKAY : `TLDTPR_RESP_SLVERR;
        end
    end

    // ==========================================================
    // writable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_fine_delay_a <= `TLDTPR_RST_DELAY;
            led_fine_delay_b <= `TLDTPR_RST_DELAY;
            led_coarse_delay <= `TLDTPR_RST_DELAY;
            pll_enable       <= 1'(`TLDTPR_RST_MODE >> `TLDTPR_PLL_EN_BIT);
            clock_control    <= `TLDTPR_RST_CLK_CTRL;
            delay_enable     <= 1'(`TLDTPR_RST_DLY_EN >> `TLDTPR_DLY_EN_BIT);
        end else if (wr_lane0) begin
            case (wr_idx)
                `TLDTPR_IDX_FINE_A:   led_fine_delay_a <= w_data_q[7:0];
                `TLDTPR_IDX_FINE_B:   led_fine_delay_b <= w_data_q[7:0];
                `TLDTPR_IDX_COARSE:   led_coarse_delay <= w_data_q[7:0];
                `TLDTPR_IDX_MODE:     pll_enable <= w_data_q[`TLDTPR_PLL_EN_BIT];
                `TLDTPR_IDX_CLK_CTRL: clock_control <= w_data_q[7:0];
                `TLDTPR_IDX_DLY_EN:   delay_enable <= w_data_q[`TLDTPR_DLY_EN_BIT];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // temperature sum: one conversion every fourth row, four per sum
    assign conv_take = row_done && (row_cnt == `TLDTPR_ROW_LAST);
    assign acc_plus  = temp_acc + 8'(temp_conv);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            row_cnt <= '0;
        end else if (row_done) begin
            row_cnt <= row_cnt + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_cnt               <= '0;
            temp_acc               <= '0;
            temp_sum_four_readings <= '0;
        end else if (conv_take) begin
            conv_cnt <= conv_cnt + 2'h1;
            if (conv_cnt == `TLDTPR_CONV_LAST) begin
                temp_sum_four_readings <= acc_plus;
                temp_acc               <= '0;
            end else begin
                temp_acc <= acc_plus;
            end
        end
    end

    // ==========================================================
    // read path
    function automatic logic [7:0] read_byte(input logic [7:0] idx);
        case (idx)
            `TLDTPR_IDX_TEMP_TL:     read_byte = temps.top_left;
            `TLDTPR_IDX_TEMP_SUM:    read_byte = temp_sum_four_readings;
            `TLDTPR_IDX_TEMP_TR:     read_byte = temps.top_right;
            `TLDTPR_IDX_TEMP_TR_AUX: read_byte = temps.top_right_aux;
            `TLDTPR_IDX_TEMP_BL:     read_byte = temps.bottom_left;
            `TLDTPR_IDX_TEMP_BL_AUX: read_byte = temps.bottom_left_aux;
            `TLDTPR_IDX_TEMP_BR:     read_byte = temps.bottom_right;
            `TLDTPR_IDX_TEMP_BR_AUX: read_byte = temps.bottom_right_aux;
            `TLDTPR_IDX_FINE_A:      read_byte = led_fine_delay_a;
            `TLDTPR_IDX_FINE_B:      read_byte = led_fine_delay_b;
            `TLDTPR_IDX_COARSE:      read_byte = led_coarse_delay;
            `TLDTPR_IDX_MODE:        read_byte = 8'({pll_enable, 2'h0});
            `TLDTPR_IDX_CLK_CTRL:    read_byte = clock_control;
            `TLDTPR_IDX_DLY_EN:      read_byte = 8'({delay_enable, 2'h0});
            default:                 read_byte = 8'h00;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `TLDTPR_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            if (addr_in_range(araddr) && idx_mapped(addr_index(araddr))) begin
                rdata <= 32'(read_byte(addr_index(araddr)));
                rresp <= `TLDTPR_RESP_OKAY;
            end else begin
                rdata <= '0;
                rresp <= `TLDTPR_RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // ==========================================================
    // led delay
    always_comb begin
        dly_cfg.enable = delay_enable;
        dly_cfg.coarse = led_coarse_delay;
        dly_cfg.fine   = {led_fine_delay_b[`TLDTPR_FINE_HI_W-1:0], led_fine_delay_a};
    end

    tldtpr_delay u_delay (
        .aclk    (aclk),
        .aresetn (aresetn),
        .dly_cfg (dly_cfg),
        .dly_out (led_delay)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic rd_tl;
    assign rd_tl = arvalid && arready && (araddr == AW'(4 * `TLDTPR_IDX_TEMP_TL));

    chk_temp_tl_read: assert property (rd_tl |=>
        rvalid && rdata == 32'($past(temps.top_left)))
        else $error("top-left temperature read wrong");
    chk_sum_publish: assert property (conv_take && conv_cnt == `TLDTPR_CONV_LAST
        |=> temp_sum_four_readings == 8'($past(temp_acc) + 8'($past(temp_conv))))
        else $error("temperature sum not published");
    chk_acc_idle_rows: assert property (!conv_take |=>
        $stable(temp_acc) && $stable(conv_cnt))
        else $error("accumulator moved without a fourth row");
    chk_pll_write: assert property (wr_lane0 && wr_idx == `TLDTPR_IDX_MODE
        |=> pll_enable == $past(w_data_q[2]) && bvalid)
        else $error("pll enable not taken from mode write");
    chk_pll_reset: assert property ($rose(aresetn) |-> pll_enable)
        else $error("pll not enabled after reset");
    chk_delay_zero_off: assert property (!delay_enable ##1 !delay_enable
        |-> led_delay == '0)
        else $error("led delay present while disabled");
    chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");

    cov_write_done: cover property (bvalid && bready);
    cov_read_done: cover property (rvalid && rready);
    cov_sum_done: cover property (conv_take && conv_cnt == `TLDTPR_CONV_LAST);
    cov_delay_on: cover property (delay_enable && led_delay.total != '0);

endmodule

//--- tldtpr_cfg.svh
// register indices, reset values, field positions and step figures of the delay/temp/pll bank
`ifndef TLDTPR_CFG_SVH
`define TLDTPR_CFG_SVH

// register indices, byte address is four times the index
`define TLDTPR_IDX_TEMP_TL      8'h60
`define TLDTPR_IDX_TEMP_SUM     8'h61
`define TLDTPR_IDX_TEMP_TR      8'h62
`define TLDTPR_IDX_TEMP_TR_AUX  8'h63
`define TLDTPR_IDX_TEMP_BL      8'h64
`define TLDTPR_IDX_TEMP_BL_AUX  8'h65
`define TLDTPR_IDX_TEMP_BR      8'h66
`define TLDTPR_IDX_TEMP_BR_AUX  8'h67
`define TLDTPR_IDX_FINE_A       8'h71
`define TLDTPR_IDX_FINE_B       8'h72
`define TLDTPR_IDX_COARSE       8'h73
`define TLDTPR_IDX_MODE         8'h7d
`define TLDTPR_IDX_CLK_CTRL     8'h80
`define TLDTPR_IDX_DLY_EN       8'hae

// reset values
`define TLDTPR_RST_DELAY        8'h00
`define TLDTPR_RST_MODE         8'h04
`define TLDTPR_RST_CLK_CTRL     8'h3f
`define TLDTPR_RST_DLY_EN       8'h00

// field positions
`define TLDTPR_PLL_EN_BIT       2
`define TLDTPR_DLY_EN_BIT       2
`define TLDTPR_FINE_HI_W        2

// delay limits and step sizes
`define TLDTPR_FINE_MAX         10'h31f
`define TLDTPR_COARSE_MAX       8'h31
`define TLDTPR_FINE_STEP_PS     10
`define TLDTPR_COARSE_STEP_PS   2000

// temperature sum cadence: last row of four, last conversion of four
`define TLDTPR_ROW_LAST         2'h3
`define TLDTPR_CONV_LAST        2'h3

// axi responses
`define TLDTPR_RESP_OKAY        2'h0
`define TLDTPR_RESP_SLVERR      2'h2

`endif

//--- tldtpr_pkg.sv
// types shared by the delay/temp/pll register bank
package tldtpr_pkg;

    // live corner sensor results, one byte each
    typedef struct packed {
        logic [7:0] top_left;
        logic [7:0] top_right;
        logic [7:0] top_right_aux;
        logic [7:0] bottom_left;
        logic [7:0] bottom_left_aux;
        logic [7:0] bottom_right;
        logic [7:0] bottom_right_aux;
    } tldtpr_temps_t;

    // delay settings as software wrote them
    typedef struct packed {
        logic       enable;
        logic [7:0] coarse;
        logic [9:0] fine;
    } tldtpr_dly_cfg_t;

    // delay actually applied to the led output; total in fine-step units
    typedef struct packed {
        logic [5:0]  coarse;
        logic [9:0]  fine;
        logic [13:0] total;
    } tldtpr_dly_out_t;

endpackage

//--- tldtpr_delay.sv
// led delay: limits, enable gating and total delay in fine-step units
`timescale 1ns/1ns
`include "tldtpr_cfg.svh"

module tldtpr_delay (
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    input  wire tldtpr_pkg::tldtpr_dly_cfg_t dly_cfg,
    output tldtpr_pkg::tldtpr_dly_out_t  dly_out
);
    import tldtpr_pkg::*;

    localparam logic [13:0] COARSE_UNITS = 14'(`TLDTPR_COARSE_STEP_PS / `TLDTPR_FINE_STEP_PS);

    logic [9:0] fine_lim;
    logic [7:0] coarse_lim;

    always_comb begin
        fine_lim   = (dly_cfg.fine > `TLDTPR_FINE_MAX) ? `TLDTPR_FINE_MAX : dly_cfg.fine;
        coarse_lim = (dly_cfg.coarse > `TLDTPR_COARSE_MAX) ? `TLDTPR_COARSE_MAX
                                                             : dly_cfg.coarse;
    end

    // disabled delay leaves the led timing untouched
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dly_out <= '0;
        end else if (dly_cfg.enable) begin
            dly_out.fine   <= fine_lim;
            dly_out.coarse <= coarse_lim[5:0];
            dly_out.total  <= 14'(14'(coarse_lim) * COARSE_UNITS + 14'(fine_lim));
        end else begin
            dly_out <= '0;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_fine_limit: assert property (dly_out.fine <= `TLDTPR_FINE_MAX)
        else $error("fine delay above limit");
    chk_coarse_limit: assert property (dly_out.coarse <= 6'(`TLDTPR_COARSE_MAX))
        else $error("coarse delay above limit");
    chk_delay_gate: assert property (!dly_cfg.enable |=> dly_out == '0)
        else $error("delay applied while disabled");
    chk_total_sum: assert property (dly_cfg.enable |=>
        dly_out.total == 14'(200 * $past(coarse_lim) + $past(fine_lim)))
        else $error("total delay is not coarse plus fine");

endmodule

//--- tb_top.sv
// self-checking testbench for the delay/temp/pll register bank
`timescale 1ns/1ns
`include "tldtpr_cfg.svh"

module tb_top;
    import tldtpr_pkg::*;

    // ========================================
    // signals
    logic            aclk      = 1'b0;
    logic            aresetn   = 1'b0;
    logic [11:0]     awaddr    = 12'h000;
    logic            awvalid   = 1'b0;
    logic            awready;
    logic [31:0]     wdata     = 32'h0000_0000;
    logic [3:0]      wstrb     = 4'h0;
    logic            wvalid    = 1'b0;
    logic            wready;
    logic [1:0]      bresp;
    logic            bvalid;
    logic            bready    = 1'b0;
    logic [11:0]     araddr    = 12'h000;
    logic            arvalid   = 1'b0;
    logic            arready;
    logic [31:0]     rdata;
    logic [1:0]      rresp;
    logic            rvalid;
    logic            rready    = 1'b0;
    tldtpr_temps_t   temps     = '0;
    logic            row_done  = 1'b0;
    logic [5:0]      temp_conv = 6'h00;
    logic            pll_enable;
    logic [7:0]      clock_control;
    tldtpr_dly_out_t led_delay;
    logic [33:0]     exp_rd[$];
    logic [1:0]      exp_wr[$];
    logic [33:0]     er;
    logic [63:0]     rnd;
    logic [7:0]      acc;
    int              n_mismatch = 0;
    int              checks_done = 0;
    int              c;
    int              f;
    int              v;

    always #2 aclk = ~aclk;

    tldtpr_regs uut (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .temps(temps), .row_done(row_done), .temp_conv(temp_conv),
        .pll_enable(pll_enable), .clock_control(clock_control), .led_delay(led_delay)
    );

    // ========================================
    // compare and closing
    task automatic check_val(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks_done %0d n_mismatch %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 200) begin
            n_mismatch++;
            $display("Error bus_wait expected handshake seen timeout");
            report_and_stop();
        end
    endtask

    function automatic logic [11:0] ba(input logic [7:0] i);
        return {2'b00, i, 2'b00};
    endfunction

    // ========================================
    // bus master
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] r);
        int   n;
        logic ad;
        logic wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        exp_wr.push_back(r);
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h00_0000, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            tick(n);
            if (awvalid === 1'b1 && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid === 1'b1 && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do tick(n); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        int n;
        n = 0;
        exp_rd.push_back({r, 24'h00_0000, d});
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do tick(n); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do tick(n); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // ========================================
    // response watcher
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            er = exp_rd.size() ? exp_rd.pop_front() : 34'h3_ffff_ffff;
            check_val("rdata", er[31:0], rdata);
            check_val("rresp", {30'h0, er[33:32]}, {30'h0, rresp});
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            check_val("bresp", {30'h0, exp_wr.size() ? exp_wr.pop_front() : 2'h3}, {30'h0, bresp});
        end
    end

    task automatic settle();
        @(posedge aclk);
        #1;
    endtask

    task automatic check_dly(input int cc, input int ff);
        check_val("led_delay", {2'b00, 6'(cc), 10'(ff), 14'(cc * 200 + ff)}, {2'b00, led_delay});
    endtask

    // ========================================
    // main sequence
    initial begin
        v = $urandom(32'h7040833f);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rnd = {$urandom, $urandom};
        temps <= rnd[55:0];
        settle();
        check_val("pll_enable", 32'h1, {31'h0, pll_enable});
        check_val("clock_control", 32'h3f, {24'h0, clock_control});
        check_dly(0, 0);
        axi_rd(ba(`TLDTPR_IDX_FINE_A), 8'h00, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_FINE_B), 8'h00, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_COARSE), 8'h00, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_MODE), 8'h04, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_CLK_CTRL), 8'h3f, `TLDTPR_RESP_OKAY);
        // corner results are live and not writable
        axi_rd(ba(`TLDTPR_IDX_TEMP_TL), temps.top_left, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_TR), temps.top_right, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_TR_AUX), temps.top_right_aux, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_BL), temps.bottom_left, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_BL_AUX), temps.bottom_left_aux, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_BR), temps.bottom_right, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_BR_AUX), temps.bottom_right_aux, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_TEMP_TL), ~temps.top_left, 4'hf, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_TEMP_TL), temps.top_left, `TLDTPR_RESP_OKAY);
        // unmapped places
        axi_rd(ba(8'h70), 8'h00, `TLDTPR_RESP_SLVERR);
        axi_wr(12'h800 | ba(`TLDTPR_IDX_COARSE), 8'h11, 4'hf, `TLDTPR_RESP_SLVERR);
        axi_rd(12'h800 | ba(`TLDTPR_IDX_COARSE), 8'h00, `TLDTPR_RESP_SLVERR);
        axi_rd(ba(`TLDTPR_IDX_COARSE), 8'h00, `TLDTPR_RESP_OKAY);
        // limits written while delay is off
        axi_wr(ba(`TLDTPR_IDX_FINE_A), 8'h1f, 4'hf, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_FINE_B), 8'h03, 4'hf, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_COARSE), 8'h31, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_dly(0, 0);
        axi_wr(ba(`TLDTPR_IDX_DLY_EN), 8'hff, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_dly(49, 799);
        axi_rd(ba(`TLDTPR_IDX_DLY_EN), 8'h04, `TLDTPR_RESP_OKAY);
        // one past each limit is clamped, register keeps the value
        axi_wr(ba(`TLDTPR_IDX_FINE_A), 8'h20, 4'hf, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_COARSE), 8'h32, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_dly(49, 799);
        axi_wr(ba(`TLDTPR_IDX_COARSE), 8'h05, 4'he, `TLDTPR_RESP_OKAY);
        axi_rd(ba(`TLDTPR_IDX_COARSE), 8'h32, `TLDTPR_RESP_OKAY);
        for (int i = 0; i < 8; i++) begin
            c = $urandom_range(0, 49);
            f = $urandom_range(0, 799);
            axi_wr(ba(`TLDTPR_IDX_FINE_A), f[7:0], 4'hf, `TLDTPR_RESP_OKAY);
            axi_wr(ba(`TLDTPR_IDX_FINE_B), {6'h00, f[9:8]}, 4'hf, `TLDTPR_RESP_OKAY);
            axi_wr(ba(`TLDTPR_IDX_COARSE), c[7:0], 4'hf, `TLDTPR_RESP_OKAY);
            settle();
            check_dly(c, f);
        end
        axi_wr(ba(`TLDTPR_IDX_DLY_EN), 8'hfb, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_dly(0, 0);
        // pll control
        axi_wr(ba(`TLDTPR_IDX_MODE), 8'h00, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_val("pll_enable", 32'h0, {31'h0, pll_enable});
        axi_rd(ba(`TLDTPR_IDX_MODE), 8'h00, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_MODE), 8'hff, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_val("pll_enable", 32'h1, {31'h0, pll_enable});
        axi_rd(ba(`TLDTPR_IDX_MODE), 8'h04, `TLDTPR_RESP_OKAY);
        axi_wr(ba(`TLDTPR_IDX_CLK_CTRL), 8'ha5, 4'hf, `TLDTPR_RESP_OKAY);
        settle();
        check_val("clock_control", 32'ha5, {24'h0, clock_control});
        axi_rd(ba(`TLDTPR_IDX_CLK_CTRL), 8'ha5, `TLDTPR_RESP_OKAY);
        // sum of every fourth row conversion over sixteen rows
        acc = 8'h00;
        for (int k = 0; k < 16; k++) begin
            v = $urandom_range(0, 63);
            @(posedge aclk);
            row_done  <= 1'b1;
            temp_conv <= v[5:0];
            if (k % 4 == 3) begin
                acc = acc + v[7:0];
            end
            @(posedge aclk);
            row_done  <= 1'b0;
            temp_conv <= ~v[5:0];
        end
        repeat (2) @(posedge aclk);
        axi_rd(ba(`TLDTPR_IDX_TEMP_SUM), acc, `TLDTPR_RESP_OKAY);
        repeat (3) @(posedge aclk);
        report_and_stop();
    end

endmodule
